// *** rtl/blk_ctrl_pkg.sv ***
// Constants for the two-channel block control logic
package blk_ctrl_pkg;
  // Register byte offsets, channel a; channel b adds CH_STRIDE
  localparam logic [7:0] OFS_MODE   = 8'h00; // Mode register pair through pointer
  localparam logic [7:0] OFS_CLK_SEL  = 8'h04; // Clock select (write), readback (read)
  localparam logic [7:0] OFS_CMD      = 8'h08; // Command register, write only
  localparam logic [7:0] OFS_IN_CHG   = 8'h0C; // Input change register, read
  localparam logic [7:0] OFS_IN_PORT  = 8'h10; // Input port register, read
  localparam logic [7:0] OFS_PORT_CFG = 8'h14; // Output port config, read and write
  localparam logic [7:0] CH_STRIDE    = 8'h20; // Channel b register spacing
  localparam logic [7:0] OFS_AUX_CTRL = 8'h18; // Block aux control (channel a slot only)
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1C; // Status read, mask write (channel a slot)
  localparam logic [7:0] OFS_IRQ_MASK = 8'h3C; // Mask readback (channel b slot)
  // Field positions
  localparam int AUX_TCLK_BIT  = 5;        // 0 selects external timer clock
  localparam int PORT_DIR_BIT  = 7;        // 1 makes both bidir pins outputs
  localparam int IN_ZERO_BIT   = 0;        // Level of aux_input_zero
  localparam int IN_ONE_BIT    = 1;        // Level of aux_input_one
  localparam int PORT_B1_BIT   = 2;        // Level of bidir_pin_one
  localparam int PORT_B2_BIT   = 3;        // Level of bidir_pin_two
  localparam int CHG_ZERO_BIT  = 4;        // Change seen on aux_input_zero
  localparam int CHG_ONE_BIT   = 5;        // Change seen on aux_input_one
  localparam int STAT_TX_A     = 0;
  localparam int STAT_RX_A     = 1;
  localparam int STAT_BRK_A    = 2;
  localparam int STAT_TC       = 3;
  localparam int STAT_TX_B     = 4;
  localparam int STAT_RX_B     = 5;
  localparam int STAT_BRK_B    = 6;
  localparam int STAT_INCHG    = 7;
  // Command and clock select encodings
  localparam logic [3:0] CMD_PTR_RST = 4'h1; // Upper nibble of command register
  localparam logic [3:0] CLK_EXT_1X  = 4'hE; // External clock, taken as 1x
  localparam logic [3:0] CLK_EXT_16X = 4'hF; // External clock, taken as 16x
  // Reset values
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;
  // Mode pointer states, one-hot
  typedef enum logic [1:0] {PTR_FIRST = 2'b01, PTR_SECOND = 2'b10} mode_ptr_t;
endpackage

// *** rtl/dual_channel_block_control.sv ***
// Register, pin and interrupt control of one two-channel serial block
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module dual_channel_block_control #(
  parameter int ADDR_W = 8
) (
  // Clock, reset, enable
  input  wire logic              sys_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              ce_i,
  // APB slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic                   pready_o,
  output logic                   pslverr_o,
  output logic [31:0]            prdata_o,
  // Aux inputs, index 0 channel a, 1 channel b
  input  wire logic [1:0]        aux_input_zero_i,
  input  wire logic [1:0]        aux_input_one_i,
  // Bidir pins, three signals each
  input  wire logic [1:0]        bidir_pin_one_i,
  output logic [1:0]             bidir_pin_one_o,
  output logic [1:0]             bidir_pin_one_oe_o,
  input  wire logic [1:0]        bidir_pin_two_i,
  output logic [1:0]             bidir_pin_two_o,
  output logic [1:0]             bidir_pin_two_oe_o,
  // Channel and timer status from the serial cores
  input  wire logic [1:0]        tx_ready_flag_i,
  input  wire logic [1:0]        rx_ready_or_full_flag_i,
  input  wire logic [1:0]        break_change_i,
  input  wire logic              timer_tc_i,
  // Clock routing to the timer and serial cores
  output logic                   timer_ext_clock_o,
  output logic                   timer_ext_sel_o,
  output logic [1:0]             tx_ext_clock_o,
  output logic [1:0]             tx_ext_sel_o,
  output logic [1:0]             tx_ext_x16_o,
  output logic [1:0]             rx_ext_clock_o,
  output logic [1:0]             rx_ext_sel_o,
  output logic [1:0]             rx_ext_x16_o,
  // Mode bytes to the serial cores
  output logic [1:0][7:0]        mode_reg_first_o,
  output logic [1:0][7:0]        mode_reg_second_o,
  // Interrupt
  output logic                   block_irq_n_o
);

  initial
  begin
    if (ADDR_W < 8)
      $error("ADDR_W must be at least 8");
  end

  // All block state
  typedef struct packed {
    logic                         pready;
    logic                         pslverr;
    logic [31:0]                  prdata;
    logic                         irq_n;
    logic [1:0][1:0]              mode_ptr;
    logic [1:0][7:0]              mode1;
    logic [1:0][7:0]              mode2;
    logic [1:0][7:0]              clk_sel;
    logic [1:0]                   port_dir;
    logic [7:0]                   aux_ctrl;
    logic [7:0]                   irq_mask;
    logic                         armed;
    logic [1:0]                   one_prev;
    logic [1:0]                   zero_prev;
    logic [1:0]                   one_chg;
    logic [1:0]                   zero_chg;
    logic [1:0]                   b1_out;
    logic [1:0]                   b2_out;
    logic                         tmr_clk;
    logic                         tmr_sel;
    logic [1:0]                   tx_clk;
    logic [1:0]                   tx_sel;
    logic [1:0]                   tx_x16;
    logic [1:0]                   rx_clk;
    logic [1:0]                   rx_sel;
    logic [1:0]                   rx_x16;
  } st_t;

  st_t st_reg;
  st_t st_next;

  logic [7:0] irq_stat;
  logic [7:0] loc;
  logic       hi_zero;
  logic       setup;
  logic       done;

  // Unmasked status word, live
  always_comb
  begin
    irq_stat                          = blk_ctrl_pkg::RST_BYTE;
    irq_stat[blk_ctrl_pkg::STAT_TX_A]  = tx_ready_flag_i[0];
    irq_stat[blk_ctrl_pkg::STAT_RX_A]  = rx_ready_or_full_flag_i[0];
    irq_stat[blk_ctrl_pkg::STAT_BRK_A] = break_change_i[0];
    irq_stat[blk_ctrl_pkg::STAT_TC]    = timer_tc_i;
    irq_stat[blk_ctrl_pkg::STAT_TX_B]  = tx_ready_flag_i[1];
    irq_stat[blk_ctrl_pkg::STAT_RX_B]  = rx_ready_or_full_flag_i[1];
    irq_stat[blk_ctrl_pkg::STAT_BRK_B] = break_change_i[1];
    irq_stat[blk_ctrl_pkg::STAT_INCHG] = (|st_reg.one_chg) | (|st_reg.zero_chg);
  end

  // Bus phase decode
  assign loc     = paddr_i[7:0];
  assign hi_zero = (paddr_i >> 8) == '0;
  assign setup   = psel_i & ~penable_i;
  assign done    = psel_i & penable_i & st_reg.pready;

  // Next state
  always_comb
  begin
    logic [7:0] rd;
    logic       hit;
    logic       ch;
    logic [7:0] off;
    logic [1:0] chg_clr;
    rd       = blk_ctrl_pkg::RST_BYTE;
    hit      = 1'b0;
    ch       = 1'b0;
    off      = loc;
    chg_clr  = 2'b00;
    st_next  = st_reg;
    st_next.pready = 1'b1;
    if (loc >= blk_ctrl_pkg::CH_STRIDE)
    begin
      ch  = 1'b1;
      off = loc - blk_ctrl_pkg::CH_STRIDE;
    end
    // Address decode shared by read data and access effects
    case (off)
      blk_ctrl_pkg::OFS_MODE:
      begin
        hit = 1'b1;
        rd  = st_reg.mode_ptr[ch][0] ? st_reg.mode1[ch] : st_reg.mode2[ch];
      end
      blk_ctrl_pkg::OFS_CLK_SEL:  begin hit = 1'b1; rd = st_reg.clk_sel[ch]; end
      blk_ctrl_pkg::OFS_CMD:  hit = 1'b1;
      blk_ctrl_pkg::OFS_IN_CHG:
      begin
        hit = 1'b1;
        rd[blk_ctrl_pkg::IN_ZERO_BIT]  = aux_input_zero_i[ch];
        rd[blk_ctrl_pkg::IN_ONE_BIT]   = aux_input_one_i[ch];
        rd[blk_ctrl_pkg::CHG_ZERO_BIT] = st_reg.zero_chg[ch];
        rd[blk_ctrl_pkg::CHG_ONE_BIT]  = st_reg.one_chg[ch];
      end
      blk_ctrl_pkg::OFS_IN_PORT:
      begin
        hit = 1'b1;
        rd[blk_ctrl_pkg::IN_ZERO_BIT] = aux_input_zero_i[ch];
        rd[blk_ctrl_pkg::IN_ONE_BIT]  = aux_input_one_i[ch];
        rd[blk_ctrl_pkg::PORT_B1_BIT] = bidir_pin_one_i[ch];
        rd[blk_ctrl_pkg::PORT_B2_BIT] = bidir_pin_two_i[ch];
      end
      blk_ctrl_pkg::OFS_PORT_CFG:
      begin
        hit = 1'b1;
        rd[blk_ctrl_pkg::PORT_DIR_BIT] = st_reg.port_dir[ch];
      end
      blk_ctrl_pkg::OFS_AUX_CTRL:
      begin
        hit = ~ch;
        rd  = st_reg.aux_ctrl;
      end
      blk_ctrl_pkg::OFS_IRQ_STAT:
      begin
        hit = 1'b1;
        rd  = ch ? st_reg.irq_mask : irq_stat;
      end
      default: hit = 1'b0;
    endcase
    hit = hit & hi_zero;
    // Read data and error are set up one cycle ahead of the access phase
    if (setup)
    begin
      st_next.prdata  = {24'h00_0000, pwrite_i ? blk_ctrl_pkg::RST_BYTE : rd};
      st_next.pslverr = ~hit;
    end
    // Effects of a completed access
    if (done && hit)
    begin
      case (off)
        blk_ctrl_pkg::OFS_MODE:
        begin
          if (pwrite_i && st_reg.mode_ptr[ch][0])
            st_next.mode1[ch] = pwdata_i[7:0];
          else if (pwrite_i)
            st_next.mode2[ch] = pwdata_i[7:0];
          st_next.mode_ptr[ch] = blk_ctrl_pkg::PTR_SECOND;
        end
        blk_ctrl_pkg::OFS_CLK_SEL:
          if (pwrite_i)
            st_next.clk_sel[ch] = pwdata_i[7:0];
        blk_ctrl_pkg::OFS_CMD:
          if (pwrite_i && pwdata_i[7:4] == blk_ctrl_pkg::CMD_PTR_RST)
            st_next.mode_ptr[ch] = blk_ctrl_pkg::PTR_FIRST;
        blk_ctrl_pkg::OFS_IN_CHG:
          if (!pwrite_i)
            chg_clr[ch] = 1'b1;
        blk_ctrl_pkg::OFS_PORT_CFG:
          if (pwrite_i)
            st_next.port_dir[ch] = pwdata_i[blk_ctrl_pkg::PORT_DIR_BIT];
        blk_ctrl_pkg::OFS_AUX_CTRL:
          if (pwrite_i)
            st_next.aux_ctrl = pwdata_i[7:0];
        blk_ctrl_pkg::OFS_IRQ_STAT:
          if (pwrite_i && !ch)
            st_next.irq_mask = pwdata_i[7:0];
        default: st_next.aux_ctrl = st_reg.aux_ctrl;
      endcase
    end
    // Change detectors; a new change beats a read clear
    // First enabled cycle after reset only loads the levels: no false change
    st_next.armed     = 1'b1;
    st_next.one_prev  = aux_input_one_i;
    st_next.zero_prev = aux_input_zero_i;
    st_next.one_chg   = (st_reg.one_chg & ~chg_clr)
                      | ((aux_input_one_i ^ st_reg.one_prev) & {2{st_reg.armed}});
    st_next.zero_chg  = (st_reg.zero_chg & ~chg_clr)
                      | ((aux_input_zero_i ^ st_reg.zero_prev) & {2{st_reg.armed}});
    // Shared active-low interrupt
    st_next.irq_n = ~|(irq_stat & st_reg.irq_mask);
    // Timer clock from channel a only
    st_next.tmr_clk = aux_input_one_i[0];
    st_next.tmr_sel = ~st_reg.aux_ctrl[blk_ctrl_pkg::AUX_TCLK_BIT];
    // Bidir pins: outputs show raw ready flags, inputs feed clocks
    st_next.b1_out = tx_ready_flag_i;
    st_next.b2_out = rx_ready_or_full_flag_i;
    st_next.tx_clk = bidir_pin_one_i;
    st_next.rx_clk = bidir_pin_two_i;
    for (int i = 0; i < 2; i++)
    begin
      st_next.tx_x16[i] = st_reg.clk_sel[i][3:0] == blk_ctrl_pkg::CLK_EXT_16X;
      st_next.tx_sel[i] = ~st_reg.port_dir[i]
                        & (st_reg.clk_sel[i][3:0] == blk_ctrl_pkg::CLK_EXT_1X
                        | st_reg.clk_sel[i][3:0] == blk_ctrl_pkg::CLK_EXT_16X);
      st_next.rx_x16[i] = st_reg.clk_sel[i][7:4] == blk_ctrl_pkg::CLK_EXT_16X;
      st_next.rx_sel[i] = ~st_reg.port_dir[i]
                        & (st_reg.clk_sel[i][7:4] == blk_ctrl_pkg::CLK_EXT_1X
                        | st_reg.clk_sel[i][7:4] == blk_ctrl_pkg::CLK_EXT_16X);
    end
  end

  // State register with clock enable
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_reg          <= '0;
      st_reg.pready   <= 1'b1;
      st_reg.irq_n    <= 1'b1;
      st_reg.prdata   <= blk_ctrl_pkg::RST_WORD;
      st_reg.mode_ptr <= {blk_ctrl_pkg::PTR_FIRST, blk_ctrl_pkg::PTR_FIRST};
    end
    else if (ce_i)
      st_reg <= st_next;
  end

  // Outputs straight from state
  assign pready_o           = st_reg.pready;
  assign pslverr_o          = st_reg.pslverr;
  assign prdata_o           = st_reg.prdata;
  assign block_irq_n_o      = st_reg.irq_n;
  assign bidir_pin_one_o    = st_reg.b1_out;
  assign bidir_pin_two_o    = st_reg.b2_out;
  assign bidir_pin_one_oe_o = st_reg.port_dir;
  assign bidir_pin_two_oe_o = st_reg.port_dir;
  assign timer_ext_clock_o  = st_reg.tmr_clk;
  assign timer_ext_sel_o    = st_reg.tmr_sel;
  assign tx_ext_clock_o     = st_reg.tx_clk;
  assign tx_ext_sel_o       = st_reg.tx_sel;
  assign tx_ext_x16_o       = st_reg.tx_x16;
  assign rx_ext_clock_o     = st_reg.rx_clk;
  assign rx_ext_sel_o       = st_reg.rx_sel;
  assign rx_ext_x16_o       = st_reg.rx_x16;
  assign mode_reg_first_o   = st_reg.mode1;
  assign mode_reg_second_o  = st_reg.mode2;

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  ptr_advance_a: assert property (ce_i && done && !pwrite_i && paddr_i == ADDR_W'(0)
    && st_reg.mode_ptr[0][0] |=> st_reg.mode_ptr[0] == blk_ctrl_pkg::PTR_SECOND)
    else $error("mode pointer did not advance");
  ptr_stays_a: assert property (st_reg.mode_ptr[0][1] && !(done && pwrite_i)
    |=> st_reg.mode_ptr[0][1])
    else $error("mode pointer left second register");
  ptr_reset_a: assert property (ce_i && done && pwrite_i
    && paddr_i == ADDR_W'(blk_ctrl_pkg::OFS_CMD)
    && pwdata_i[7:4] == blk_ctrl_pkg::CMD_PTR_RST
    |=> st_reg.mode_ptr[0] == blk_ctrl_pkg::PTR_FIRST)
    else $error("pointer command ignored");
  irq_mask_a: assert property (ce_i |=> block_irq_n_o
    == !(|($past(irq_stat) & $past(st_reg.irq_mask))))
    else $error("interrupt does not follow masked status");
  pin_dir_a: assert property (bidir_pin_one_oe_o == st_reg.port_dir
    && bidir_pin_two_oe_o == bidir_pin_one_oe_o)
    else $error("bidir direction mismatch");
  tx_flag_pin_a: assert property (ce_i |=> bidir_pin_one_o == $past(tx_ready_flag_i))
    else $error("tx ready not on pin");
  rx_flag_pin_a: assert property (ce_i |=> bidir_pin_two_o == $past(rx_ready_or_full_flag_i))
    else $error("rx ready not on pin");
  timer_src_a: assert property (ce_i |=> timer_ext_sel_o
    == !$past(st_reg.aux_ctrl[blk_ctrl_pkg::AUX_TCLK_BIT]))
    else $error("timer clock select wrong");
  change_det_a: assert property (ce_i && st_reg.armed
    && aux_input_one_i[0] != st_reg.one_prev[0]
    |=> st_reg.one_chg[0] ##1 (!ce_i || st_reg.one_chg[0] || $past(done)))
    else $error("input change lost");
  isr_read_a: assert property (ce_i && setup && !pwrite_i
    && paddr_i == ADDR_W'(blk_ctrl_pkg::OFS_IRQ_STAT)
    |=> prdata_o[7:0] == $past(irq_stat))
    else $error("status read masked");

  ptr_cycle_c: cover property (st_reg.mode_ptr[0][1] ##[1:20] st_reg.mode_ptr[0][0]);
  irq_fire_c:  cover property (block_irq_n_o ##1 !block_irq_n_o);
  pin_out_c:   cover property (bidir_pin_one_oe_o[0] && bidir_pin_one_o[0]);
  change_c:    cover property (st_reg.one_chg[1]);
  ext_clk_c:   cover property (tx_ext_sel_o[0] && tx_ext_clock_o[0]);

endmodule

// *** verification/pin_model.sv ***
// Far side of the two-way pins: external drivers plus pull-ups
`timescale 1ns/1ps
module pin_model (
  // Block side
  input  wire logic [1:0] oe_i,
  input  wire logic [1:0] drv_i,
  // External driver
  input  wire logic [1:0] ext_en_i,
  input  wire logic [1:0] ext_val_i,
  // Resolved pin level
  output logic [1:0]      level_o
);
  // Block wins while driving, else outside driver, else the pull-up
  always_comb
  begin
    for (int k = 0; k < 2; k++)
    begin
      level_o[k] = oe_i[k] ? drv_i[k] : (ext_en_i[k] ? ext_val_i[k] : 1'b1);
    end
  end
endmodule

// *** verification/tb_dual_channel_block_control.sv ***
// Self-checking bench of the two-channel block control logic
`timescale 1ns/1ps
module tb_dual_channel_block_control;
  typedef struct packed {
    logic [1:0] tx; logic [1:0] rx; logic [1:0] brk; logic tc;
    logic [7:0] mask; logic [7:0] stat; logic irq_n;
  } row_t;
  localparam row_t ROWS [6] = '{
    '{2'b00, 2'b00, 2'b00, 1'b0, 8'hFF, 8'h00, 1'b1},
    '{2'b01, 2'b00, 2'b00, 1'b0, 8'h01, 8'h01, 1'b0},
    '{2'b10, 2'b01, 2'b00, 1'b0, 8'h01, 8'h12, 1'b1},
    '{2'b00, 2'b00, 2'b11, 1'b1, 8'h40, 8'h4C, 1'b0},
    '{2'b11, 2'b11, 2'b11, 1'b1, 8'h00, 8'h7F, 1'b1},
    '{2'b00, 2'b10, 2'b00, 1'b0, 8'h20, 8'h20, 1'b0}};
  logic sys_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, last_err, timer_clk, timer_sel, irq_n, tc = 1'b0;
  logic [1:0] az = 2'b00, ao = 2'b00, tx = 2'b00, rx = 2'b00, brk = 2'b00;
  logic [1:0] e1_en = 2'b00, e1_val = 2'b00, e2_en = 2'b00, e2_val = 2'b00;
  logic [1:0] lvl1, lvl2, drv1, drv2, oe1, oe2, txc, txs, tx16, rxc, rxs, rx16;
  logic [1:0][7:0] mode1, mode2;
  logic ce = 1'b1;
  int n_errors = 0, checked = 0;
  // Clock, 100 MHz
  always #5 sys_clk = ~sys_clk;
  dual_channel_block_control dual_channel_block_control_inst (
    .sys_clk_i(sys_clk), .rst_b_i(rst_b), .ce_i(ce), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
    .pslverr_o(pslverr), .prdata_o(prdata), .aux_input_zero_i(az), .aux_input_one_i(ao),
    .bidir_pin_one_i(lvl1), .bidir_pin_one_o(drv1), .bidir_pin_one_oe_o(oe1),
    .bidir_pin_two_i(lvl2), .bidir_pin_two_o(drv2), .bidir_pin_two_oe_o(oe2),
    .tx_ready_flag_i(tx), .rx_ready_or_full_flag_i(rx), .break_change_i(brk),
    .timer_tc_i(tc), .timer_ext_clock_o(timer_clk), .timer_ext_sel_o(timer_sel),
    .tx_ext_clock_o(txc), .tx_ext_sel_o(txs), .tx_ext_x16_o(tx16), .rx_ext_clock_o(rxc),
    .rx_ext_sel_o(rxs), .rx_ext_x16_o(rx16), .mode_reg_first_o(mode1),
    .mode_reg_second_o(mode2), .block_irq_n_o(irq_n));
  pin_model pin_one_inst (.oe_i(oe1), .drv_i(drv1), .ext_en_i(e1_en), .ext_val_i(e1_val),
    .level_o(lvl1));
  pin_model pin_two_inst (.oe_i(oe2), .drv_i(drv2), .ext_en_i(e2_en), .ext_val_i(e2_val),
    .level_o(lvl2));
  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Compare one value
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Wait ends once pready is sampled high; the hang guard ends it if pready never rises
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    rdata = prdata;
    last_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rdata);
  endtask
  // Let input changes settle through the registered paths
  task automatic settle();
    repeat (3) @(posedge sys_clk);
  endtask
  // Hang guard
  initial
  begin
    #200000;
    n_errors++;
    wrap_up();
  end
  // Main sequence
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    settle();
    chk("irq_rst", 32'h1, irq_n);
    chk("oe_rst", 32'h0, {oe1, oe2});
    wr(8'h14, 32'h80);
    wr(8'h34, 32'h80);
    settle();
    chk("oe_out", 32'hF, {oe1, oe2});
    // Table of status and mask cases
    foreach (ROWS[i])
    begin
      tx <= ROWS[i].tx; rx <= ROWS[i].rx; brk <= ROWS[i].brk; tc <= ROWS[i].tc;
      wr(8'h1C, {24'h0, ROWS[i].mask});
      settle();
      rdchk("stat", 8'h1C, {24'h0, ROWS[i].stat});
      chk("irq", {31'h0, ROWS[i].irq_n}, irq_n);
      chk("pin_tx", {30'h0, ROWS[i].tx}, drv1);
      chk("pin_rx", {30'h0, ROWS[i].rx}, drv2);
      rdchk("ipr_out", 8'h10, {28'h0, ROWS[i].rx[0], ROWS[i].tx[0], 2'b00});
    end
    rdchk("mask_back", 8'h3C, 32'h20);
    tx <= 2'b00; rx <= 2'b00; brk <= 2'b00; tc <= 1'b0;
    // Mode register pointer
    wr(8'h00, 32'hA1);
    chk("mode1", 32'hA1, mode1[0]);
    wr(8'h00, 32'hB2);
    chk("mode2", 32'hB2, mode2[0]);
    chk("mode1_keep", 32'hA1, mode1[0]);
    wr(8'h00, 32'hC3);
    chk("mode2_stay", 32'hC3, mode2[0]);
    rdchk("rd_stay", 8'h00, 32'hC3);
    wr(8'h08, 32'h10);
    rdchk("rd_first", 8'h00, 32'hA1);
    rdchk("rd_moved", 8'h00, 32'hC3);
    wr(8'h20, 32'hD4);
    chk("mode1_b", 32'hD4, mode1[1]);
    chk("mode2_b", 32'h0, mode2[1]);
    // Aux inputs, change detection, input change interrupt
    wr(8'h14, 32'h00);
    wr(8'h34, 32'h00);
    wr(8'h1C, 32'h80);
    az <= 2'b01; ao <= 2'b10;
    settle();
    chk("irq_chg", 32'h0, irq_n);
    chk("timer_b", 32'h0, timer_clk);
    rdchk("ipr_a", 8'h10, 32'h0D);
    rdchk("ipr_b", 8'h30, 32'h0E);
    rdchk("input_change_reg_a", 8'h0C, 32'h11);
    rdchk("input_change_reg_a2", 8'h0C, 32'h01);
    rdchk("input_change_reg_b", 8'h2C, 32'h22);
    settle();
    chk("irq_clr", 32'h1, irq_n);
    // Timer clock routing
    wr(8'h18, 32'h00);
    ao <= 2'b01;
    settle();
    chk("tsel", 32'h1, timer_sel);
    chk("tclk", 32'h1, timer_clk);
    wr(8'h18, 32'h20);
    settle();
    chk("tsel_off", 32'h0, timer_sel);
    // External serial clocks on the bidir pins
    wr(8'h04, 32'hFE);
    e1_en <= 2'b01; e1_val <= 2'b00; e2_en <= 2'b01; e2_val <= 2'b00;
    settle();
    chk("tx_sel", 32'h1, {tx16[0], txs[0]});
    chk("rx_sel", 32'h3, {rx16[0], rxs[0]});
    chk("clk_lo", 32'h0, {rxc[0], txc[0]});
    e1_val <= 2'b01; e2_val <= 2'b01;
    settle();
    chk("clk_hi", 32'h3, {rxc[0], txc[0]});
    e1_en <= 2'b00; e2_en <= 2'b00;
    wr(8'h14, 32'h80);
    settle();
    chk("sel_out", 32'h0, {rxs[0], txs[0]});
    // Unmapped place
    rdchk("unmapped", 8'h40, 32'h0);
    chk("err", 32'h1, last_err);
    // Write while the clock enable is low must not land
    ce <= 1'b0;
    wr(8'h04, 32'h12);
    ce <= 1'b1;
    rdchk("csr", 8'h04, 32'hFE);
    chk("no_err", 32'h0, last_err);
    // Second reset in mid-run
    @(posedge sys_clk);
    rst_b <= 1'b0;
    settle();
    rst_b <= 1'b1;
    settle();
    chk("oe_rst2", 32'h0, {oe1, oe2});
    wr(8'h00, 32'hE5);
    chk("mode1_rst2", 32'hE5, mode1[0]);
    wrap_up();
  end
endmodule
